// *** ist_delay_line.sv ***
/*
 * Sample-and-delay stage: shifts a bit one place per advance strobe.
 * Assumes advance is a one-cycle strobe from logic on the same clock.
 */
module ist_delay_line
    import ist_pkg::*;
#(
    parameter int unsigned DEPTH = 4
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic advance,
    input  wire logic dataIn,
    output logic      dataOut
);

    logic [DEPTH-1:0] taps_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            taps_q <= '0;
        end else if (advance) begin
            taps_q <= {taps_q[DEPTH-2:0], dataIn};
        end
    end

    assign dataOut = taps_q[DEPTH-1];

endmodule // ist_delay_line

// *** ist_pkg.sv ***
/*
 * Constants and types shared by the imager scan timing block.
 * Assumes a single clock domain; every count is in clock cycles or events.
 */
package ist_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock division
    localparam int unsigned IST_SYNC_DIV       = 16;
    localparam int unsigned IST_SYNC_DIV_W     = $clog2(IST_SYNC_DIV);
    localparam int unsigned IST_SEQ_SLOTS      = 7;
    localparam logic [6:0]  IST_SEQ_FIRST      = 7'h01;
    localparam logic [6:0]  IST_SEQ_RST        = 7'h00;

    ////////////////////////////////////////////////////////////////////////
    // Sample and delay stages, counted in element periods
    localparam int unsigned IST_HDATA_DELAY    = 4;
    localparam int unsigned IST_VDATA_DELAY    = 4;
    localparam int unsigned IST_ROWLOAD_DELAY  = 4;

    ////////////////////////////////////////////////////////////////////////
    // Line and field counting
    localparam int unsigned IST_FIELD_IDX_W    = 4;
    localparam int unsigned IST_LINES_PER_FLD  = 262;
    localparam int unsigned IST_LINE_CNT_W     = 9;
    localparam int unsigned IST_VEN_LINES      = 242;
    localparam logic [8:0]  IST_LINE_CNT_RST   = 9'h000;

    ////////////////////////////////////////////////////////////////////////
    // Modes and states
    typedef enum logic {
        IST_PRE_INJECT_READOUT,
        IST_NONDESTRUCTIVE_READOUT
    } ist_readout_t;

    typedef enum logic [1:0] {
        IST_INJ_IDLE,
        IST_INJ_ARMED,
        IST_INJ_FIRE
    } ist_inject_t;

endpackage

// *** ist_scan_timing.sv ***
/*
 * Scan timing generator for a charge-injection imager camera: element-rate
 * sequencer, horizontal phases, sample pulse, gates, sync generator clock,
 * and line/field processing of the external sync generator outputs.
 * Assumes clk is the master clock; every sync generator output and every
 * mode pin is asynchronous and passes a two-stage synchroniser.
 */
// Notes on behaviour
// - Master clock divided by sixteen for sync generator
// - Half-rate clock steps a seven-slot sequencer
// - One-hot slots, one half-rate period each
// - End of seventh slot returns sequencer
// - Seventh slot toggles horizontal phase pair
// - Inverted sixth slot is sample pulse
// - Sync wave: sample rise to end of slot one
// - High-frequency gate at seventh-slot rate
// - Horizontal data from sampled delayed burst flag
// - Vertical data from sampled delayed field index
// - Vertical phase from divided gated horizontal drive
// - Vertical enable: field counter gated, mode mux
// - Row-load gate from delayed inverted line pulse
// - Horizontal reset from inverted drive edge
// - Interlace mode resets sync generator every field
// - Interlace video gate blanks alternate lines
// - Level switch triggers injection in nondestructive mode
// - Row-load gate depends on readout mode
module ist_scan_timing
    import ist_pkg::*;
#(
    parameter int unsigned FIELD_IDX_W   = IST_FIELD_IDX_W,
    parameter int unsigned LINES_PER_FLD = IST_LINES_PER_FLD,
    parameter int unsigned VEN_LINES     = IST_VEN_LINES
) (
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic                   hDrivePin,
    input  wire logic                   burstFlagPin,
    input  wire logic [FIELD_IDX_W-1:0] fieldIndexPin,
    input  wire logic                   lineNegPin,
    input  wire logic                   levelSwitchPin,
    input  wire logic                   ndroSelectPin,
    input  wire logic                   interlaceSelectPin,
    output logic                        syncGenClk,
    output logic [IST_SEQ_SLOTS-1:0]    seqSlot,
    output logic                        hPhaseA,
    output logic                        hPhaseB,
    output logic                        samplePulse,
    output logic                        syncClkWave,
    output logic                        hfGate,
    output logic                        hData,
    output logic                        vData,
    output logic                        vPhase,
    output logic                        vEnable,
    output logic                        rowLoadGate,
    output logic                        hReset,
    output logic                        syncGenReset,
    output logic                        videoGate,
    output logic                        injectCharge
);

    localparam int unsigned NPIN = FIELD_IDX_W + 6;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [NPIN-1:0]        pinSync;
    logic                   hDriveS;
    logic                   burstFlagS;
    logic [FIELD_IDX_W-1:0] fieldIndexS;
    logic                   lineNegS;
    logic                   levelSwS;
    logic                   ndroSelS;
    logic                   interlaceS;

    ist_sync2 #(
        .W (NPIN)
    ) u_pin_sync (
        .clk     (clk),
        .srst    (srst),
        .pinIn   ({interlaceSelectPin, ndroSelectPin, levelSwitchPin,
                   lineNegPin, fieldIndexPin, burstFlagPin, hDrivePin}),
        .syncOut (pinSync)
    );

    assign hDriveS     = pinSync[0];
    assign burstFlagS  = pinSync[1];
    assign fieldIndexS = pinSync[FIELD_IDX_W+1:2];
    assign lineNegS    = pinSync[FIELD_IDX_W+2];
    assign levelSwS    = pinSync[FIELD_IDX_W+3];
    assign ndroSelS    = pinSync[FIELD_IDX_W+4];
    assign interlaceS  = pinSync[FIELD_IDX_W+5];

    ist_readout_t readoutMode;
    assign readoutMode = ndroSelS ? IST_NONDESTRUCTIVE_READOUT
                                  : IST_PRE_INJECT_READOUT;

    ////////////////////////////////////////////////////////////////////////
    // Master clock division

    logic                      divA_q;
    logic [IST_SYNC_DIV_W-2:0] divB_q;
    logic                      halfTick;

    always_ff @(posedge clk) begin
        if (srst) begin
            divA_q <= 1'b0;
            divB_q <= '0;
        end else begin
            divA_q <= ~divA_q;
            if (divA_q) begin
                divB_q <= divB_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            syncGenClk <= 1'b0;
        end else begin
            syncGenClk <= (divA_q && (&divB_q[IST_SYNC_DIV_W-3:0]))
                          ? ~divB_q[IST_SYNC_DIV_W-2]
                          : divB_q[IST_SYNC_DIV_W-2];
        end
    end

    assign halfTick = divA_q;

    ////////////////////////////////////////////////////////////////////////
    // Seven-slot sequencer

    logic [IST_SEQ_SLOTS-1:0] seq_q;
    logic                     seqEnd;

    assign seqEnd = halfTick && seq_q[IST_SEQ_SLOTS-1];

    always_ff @(posedge clk) begin
        if (srst) begin
            seq_q <= IST_SEQ_RST;
        end else if (halfTick) begin
            if (seqEnd || (seq_q == IST_SEQ_RST)) begin
                seq_q <= IST_SEQ_FIRST;
            end else begin
                seq_q <= {seq_q[IST_SEQ_SLOTS-2:0], 1'b0};
            end
        end
    end

    assign seqSlot = seq_q;

    ////////////////////////////////////////////////////////////////////////
    // Element-rate pulses

    always_ff @(posedge clk) begin
        if (srst) begin
            hPhaseA <= 1'b0;
            hPhaseB <= 1'b1;
        end else if (seqEnd) begin
            hPhaseA <= ~hPhaseA;
            hPhaseB <= hPhaseA;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            samplePulse <= 1'b1;
        end else begin
            samplePulse <= ~seq_q[5];
        end
    end

    logic sampleLast_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            sampleLast_q <= 1'b1;
        end else begin
            sampleLast_q <= samplePulse;
        end
    end

    // start at sample rise, stop at end of slot one
    always_ff @(posedge clk) begin
        if (srst) begin
            syncClkWave <= 1'b0;
        end else if (samplePulse && !sampleLast_q) begin
            syncClkWave <= 1'b1;
        end else if (seq_q[0] && halfTick) begin
            syncClkWave <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            hfGate <= 1'b0;
        end else begin
            hfGate <= seq_q[6] | seq_q[0] | seq_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Horizontal reset and drive division

    logic hDriveLast_q;
    logic hEdge;

    always_ff @(posedge clk) begin
        if (srst) begin
            hDriveLast_q <= 1'b0;
        end else begin
            hDriveLast_q <= hDriveS;
        end
    end

    assign hEdge = hDriveLast_q && !hDriveS;

    always_ff @(posedge clk) begin
        if (srst) begin
            hReset <= 1'b0;
        end else begin
            hReset <= hEdge;
        end
    end

    logic hDiv_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            hDiv_q <= 1'b0;
            vPhase <= 1'b0;
        end else begin
            if (hEdge) begin
                hDiv_q <= ~hDiv_q;
            end
            vPhase <= (hDiv_q ^ hEdge) && !hDriveS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sampled and delayed data pulses

    logic hDataRaw;
    logic vDataRaw;
    logic rowLoadRaw;

    ist_delay_line #(
        .DEPTH (IST_HDATA_DELAY)
    ) u_hdata_dly (
        .clk     (clk),
        .srst    (srst),
        .advance (seqEnd),
        .dataIn  (burstFlagS),
        .dataOut (hDataRaw)
    );

    ist_delay_line #(
        .DEPTH (IST_VDATA_DELAY)
    ) u_vdata_dly (
        .clk     (clk),
        .srst    (srst),
        .advance (seqEnd),
        .dataIn  (|fieldIndexS),
        .dataOut (vDataRaw)
    );

    ist_delay_line #(
        .DEPTH (IST_ROWLOAD_DELAY)
    ) u_rowload_dly (
        .clk     (clk),
        .srst    (srst),
        .advance (seqEnd),
        .dataIn  (lineNegS),
        .dataOut (rowLoadRaw)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            hData <= 1'b0;
            vData <= 1'b0;
        end else begin
            hData <= hDataRaw;
            vData <= vDataRaw;
        end
    end

    logic vDataLast_q;
    logic fieldStart;

    always_ff @(posedge clk) begin
        if (srst) begin
            vDataLast_q <= 1'b0;
        end else begin
            vDataLast_q <= vData;
        end
    end

    assign fieldStart = vData && !vDataLast_q;

    ////////////////////////////////////////////////////////////////////////
    // Charge injection control

    ist_inject_t inj_q;
    logic        levelLast_q;
    logic        levelRise;

    always_ff @(posedge clk) begin
        if (srst) begin
            levelLast_q <= 1'b0;
        end else begin
            levelLast_q <= levelSwS;
        end
    end

    assign levelRise = levelSwS && !levelLast_q;

    // arm on level switch, fire for one line at field start
    always_ff @(posedge clk) begin
        if (srst) begin
            inj_q <= IST_INJ_IDLE;
        end else begin
            case (inj_q)
                IST_INJ_IDLE: begin
                    if (readoutMode == IST_NONDESTRUCTIVE_READOUT
                        && levelRise) begin
                        inj_q <= IST_INJ_ARMED;
                    end
                end
                IST_INJ_ARMED: begin
                    if (readoutMode != IST_NONDESTRUCTIVE_READOUT) begin
                        inj_q <= IST_INJ_IDLE;
                    end else if (fieldStart) begin
                        inj_q <= IST_INJ_FIRE;
                    end
                end
                IST_INJ_FIRE: begin
                    if (hReset) begin
                        inj_q <= IST_INJ_IDLE;
                    end
                end
                default: begin
                    inj_q <= IST_INJ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            injectCharge <= 1'b0;
        end else begin
            injectCharge <= (inj_q == IST_INJ_FIRE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Row-load gate and vertical enable

    // every line in pre-inject, only injecting lines otherwise
    always_ff @(posedge clk) begin
        if (srst) begin
            rowLoadGate <= 1'b0;
        end else if (readoutMode == IST_PRE_INJECT_READOUT) begin
            rowLoadGate <= rowLoadRaw;
        end else begin
            rowLoadGate <= rowLoadRaw && (inj_q == IST_INJ_FIRE);
        end
    end

    logic [IST_LINE_CNT_W-1:0] fieldLine_q;
    logic                      venSelect;

    always_ff @(posedge clk) begin
        if (srst) begin
            fieldLine_q <= IST_LINE_CNT_RST;
        end else if (fieldStart) begin
            fieldLine_q <= IST_LINE_CNT_RST;
        end else if (hReset && fieldLine_q < IST_LINE_CNT_W'(VEN_LINES)) begin
            fieldLine_q <= fieldLine_q + 1'b1;
        end
    end

    assign venSelect = (readoutMode == IST_PRE_INJECT_READOUT)
                       ? (vPhase && !hDriveS)
                       : (rowLoadGate && !hDriveS);

    always_ff @(posedge clk) begin
        if (srst) begin
            vEnable <= 1'b0;
        end else begin
            vEnable <= venSelect
                       && (fieldLine_q < IST_LINE_CNT_W'(VEN_LINES));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synthetic interlace

    logic [IST_LINE_CNT_W-1:0] line_q;
    logic                      fieldTwo_q;
    logic                      lastLine;

    assign lastLine = (line_q == IST_LINE_CNT_W'(LINES_PER_FLD - 1));

    always_ff @(posedge clk) begin
        if (srst) begin
            line_q       <= IST_LINE_CNT_RST;
            fieldTwo_q   <= 1'b0;
            syncGenReset <= 1'b0;
        end else if (!interlaceS) begin
            line_q       <= IST_LINE_CNT_RST;
            fieldTwo_q   <= 1'b0;
            syncGenReset <= 1'b0;
        end else begin
            syncGenReset <= hReset && lastLine;
            if (hReset) begin
                if (lastLine) begin
                    line_q     <= IST_LINE_CNT_RST;
                    fieldTwo_q <= ~fieldTwo_q;
                end else begin
                    line_q <= line_q + 1'b1;
                end
            end
        end
    end

    // blank even lines in field one, odd in field two
    always_ff @(posedge clk) begin
        if (srst) begin
            videoGate <= 1'b1;
        end else if (!interlaceS) begin
            videoGate <= 1'b1;
        end else begin
            videoGate <= fieldTwo_q ? !line_q[0] : line_q[0];
        end
    end

endmodule // ist_scan_timing

// *** ist_scan_timing_checker.sv ***
/*
 * Checker for the scan timing block: sequencer, phases and line pulses.
 * Assumes one clock domain and a synchronous active-high reset.
 */
module ist_scan_timing_checker
    import ist_pkg::*;
(
    input wire logic                     clk,
    input wire logic                     srst,
    input wire logic                     hDrivePin,
    input wire logic                     syncGenClk,
    input wire logic [IST_SEQ_SLOTS-1:0] seqSlot,
    input wire logic                     hPhaseA,
    input wire logic                     hPhaseB,
    input wire logic                     samplePulse,
    input wire logic                     syncClkWave,
    input wire logic                     hfGate,
    input wire logic                     vPhase,
    input wire logic                     hReset,
    input wire logic                     syncGenReset
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    sequence sampleLowPair;
        !samplePulse ##1 samplePulse;
    endsequence
    sequence waveRun;
        syncClkWave ##[1:6] !syncClkWave;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // sixteen-way divide, sequencer, phases and line pulses
    chk_sync_div_half: assert property ($changed(syncGenClk) |=>
        $stable(syncGenClk) [*7] ##1 $changed(syncGenClk))
        else $error("syncGenClk half period is not 8 clocks");
    chk_seq_walk_slot: assert property (($changed(seqSlot) &&
        seqSlot != IST_SEQ_RST) |=> $stable(seqSlot) ##1
        (seqSlot == {$past(seqSlot[5:0], 2), $past(seqSlot[6], 2)}))
        else $error("seqSlot did not step one slot per two clocks");
    chk_seq_one_hot: assert property ($onehot0(seqSlot))
        else $error("seqSlot has more than one slot set");
    chk_phase_pair: assert property (hPhaseB == !hPhaseA)
        else $error("hPhaseB is not the complement of hPhaseA");
    chk_phase_toggle_end: assert property ($changed(hPhaseA) ==
        (seqSlot == IST_SEQ_FIRST && $past(seqSlot[6])))
        else $error("hPhaseA toggle not at end of slot seven");
    chk_sample_slot_six: assert property ($fell(samplePulse) |->
        $past(seqSlot[5]) ##1 sampleLowPair)
        else $error("samplePulse low outside slot six");
    chk_sync_wave_span: assert property ($rose(samplePulse) |=>
        waveRun)
        else $error("syncClkWave not started or not ended");
    chk_hf_gate_slots: assert property (hfGate ==
        $past(seqSlot[6] | seqSlot[0] | seqSlot[1]))
        else $error("hfGate does not follow its slots");
    chk_hreset_pulse: assert property ($fell(hDrivePin) |->
        ##[2:5] hReset ##1 !hReset)
        else $error("hReset missing or wider than one clock");
    chk_field_reset_cause: assert property (syncGenReset |->
        $past(hReset) ##1 !syncGenReset)
        else $error("syncGenReset without preceding hReset");
    chk_vphase_gate: assert property (vPhase |->
        !$past(hDrivePin, 3))
        else $error("vPhase high during horizontal drive");
endmodule // ist_scan_timing_checker

bind ist_scan_timing ist_scan_timing_checker ist_scan_timing_checker_i (
    .clk, .srst, .hDrivePin, .syncGenClk, .seqSlot, .hPhaseA, .hPhaseB,
    .samplePulse, .syncClkWave, .hfGate, .vPhase, .hReset, .syncGenReset
);

// *** ist_sync2.sv ***
/*
 * Two-stage synchroniser for a group of pin inputs.
 * Assumes the pins are asynchronous to clk; only the second stage is read.
 */
module ist_sync2
    import ist_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] syncOut
);

    logic [W-1:0] stage1_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            stage1_q <= '0;
            syncOut  <= '0;
        end else begin
            stage1_q <= pinIn;
            syncOut  <= stage1_q;
        end
    end

endmodule // ist_sync2

// *** ist_sync_partner.sv ***
/*
 * Model of the TV sync generator and the video level detector.
 * Assumes syncGenClk comes from the block; timing is per divided tick.
 */
module ist_sync_partner
    import ist_pkg::*;
#(
    parameter int unsigned LINE_TICKS  = 6,
    parameter int unsigned FIELD_LINES = 10
) (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic                       syncGenClk,
    input  wire logic                       syncGenReset,
    input  wire logic                       levelHigh,
    output logic                            hDrivePin,
    output logic                            burstFlagPin,
    output logic [IST_FIELD_IDX_W-1:0]      fieldIndexPin,
    output logic                            lineNegPin,
    output logic                            levelSwitchPin
);
    timeunit 1ns;
    timeprecision 1ns;

    logic       sgClkQ;
    logic       fieldRstQ;
    logic [3:0] tickQ;
    logic [7:0] lineQ;

    // pulses on divided clock, field reset
    always @(posedge clk) begin
        sgClkQ <= syncGenClk;
        if (srst) begin
            tickQ     <= 4'h0;
            lineQ     <= 8'h00;
            fieldRstQ <= 1'b0;
        end else begin
            if (syncGenReset)
                fieldRstQ <= 1'b1;
            if (syncGenClk && !sgClkQ) begin
                tickQ <= (tickQ == 4'(LINE_TICKS - 1)) ? 4'h0 : tickQ + 4'h1;
                if (tickQ == 4'(LINE_TICKS - 1)) begin
                    lineQ     <= (fieldRstQ ||
                        lineQ == 8'(FIELD_LINES - 1)) ? 8'h00 : lineQ + 8'h01;
                    fieldRstQ <= 1'b0;
                end
            end
        end
    end

    assign hDrivePin     = (tickQ < 4'h2);
    assign burstFlagPin  = (tickQ == 4'h3);
    assign lineNegPin    = (tickQ != 4'h4);
    assign fieldIndexPin = (lineQ == 8'h00) ? 4'h1 : 4'h0;
    assign levelSwitchPin = levelHigh;
endmodule // ist_sync_partner

// *** test_imager_scan_timing.sv ***
/*
 * Testbench for the scan timing block with a sync generator model.
 * Assumes a 10 MHz clock and a synchronous active-high reset.
 */
`define CHK(what, exp, got) begin comparisons++; \
    if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR %s expected %0h seen %0h", what, exp, got); end end

module test_imager_scan_timing
    import ist_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int unsigned LPF       = 8;
    localparam int unsigned FIELD_CLK = 6720;

    logic clk, srst, levelHigh, readoutSel, interlaceSel;
    logic hDrivePin, burstFlagPin, lineNegPin, levelSwitchPin;
    logic [IST_FIELD_IDX_W-1:0] fieldIndexPin;
    logic [IST_SEQ_SLOTS-1:0]   seqSlot;
    logic syncGenClk, hPhaseA, hPhaseB, samplePulse, syncClkWave, hfGate;
    logic hData, vData, vPhase, vEnable, rowLoadGate, hReset;
    logic syncGenReset, videoGate, injectCharge;
    logic [5:0] prevQ;
    int num_errors, comparisons;
    int nSg, nSeq, nPh, nHd, nVd, nVp, nHr, nInj, nRow, nVen;

    ist_scan_timing #(.LINES_PER_FLD(LPF), .VEN_LINES(5)) ist_scan_timing_i (
        .clk(clk), .srst(srst), .hDrivePin(hDrivePin),
        .burstFlagPin(burstFlagPin), .fieldIndexPin(fieldIndexPin),
        .lineNegPin(lineNegPin), .levelSwitchPin(levelSwitchPin),
        .ndroSelectPin(readoutSel), .interlaceSelectPin(interlaceSel),
        .syncGenClk(syncGenClk), .seqSlot(seqSlot), .hPhaseA(hPhaseA),
        .hPhaseB(hPhaseB), .samplePulse(samplePulse),
        .syncClkWave(syncClkWave), .hfGate(hfGate), .hData(hData),
        .vData(vData), .vPhase(vPhase), .vEnable(vEnable),
        .rowLoadGate(rowLoadGate), .hReset(hReset),
        .syncGenReset(syncGenReset), .videoGate(videoGate),
        .injectCharge(injectCharge));

    ist_sync_partner ist_sync_partner_i (
        .clk(clk), .srst(srst), .syncGenClk(syncGenClk),
        .syncGenReset(syncGenReset), .levelHigh(levelHigh),
        .hDrivePin(hDrivePin), .burstFlagPin(burstFlagPin),
        .fieldIndexPin(fieldIndexPin), .lineNegPin(lineNegPin),
        .levelSwitchPin(levelSwitchPin));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge and level counters
    always @(posedge clk) begin
        prevQ <= {syncGenClk, seqSlot[0], hPhaseA, hData, vData, vPhase};
        nSg  += int'(syncGenClk & ~prevQ[5]);
        nSeq += int'(seqSlot[0] & ~prevQ[4]);
        nPh  += int'(hPhaseA & ~prevQ[3]);
        nHd  += int'(hData & ~prevQ[2]);
        nVd  += int'(vData & ~prevQ[1]);
        nVp  += int'(vPhase & ~prevQ[0]);
        nHr  += int'(hReset);
        nInj += int'(injectCharge);
        nRow += int'(rowLoadGate);
        nVen += int'(vEnable);
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic check_reset();
        `CHK("seqSlot", IST_SEQ_RST, seqSlot)
        `CHK("hPhaseB", 1'b1, hPhaseB)
        `CHK("samplePulse", 1'b1, samplePulse)
    endtask

    task automatic check_rates();
        int s0, q0, p0, k;
        s0 = nSg;
        q0 = nSeq;
        p0 = nPh;
        tick(224);
        `CHK("syncGenClk rises", 14, nSg - s0)
        `CHK("sequence starts", 16, nSeq - q0)
        `CHK("hPhaseA rises", 8, nPh - p0)
        for (k = 0; k < 30 && seqSlot !== 7'h40; k++) tick(1);
        for (k = 0; k < 30 && seqSlot !== IST_SEQ_FIRST; k++) tick(1);
        for (k = 0; k < 14; k++) begin
            `CHK("seqSlot", IST_SEQ_FIRST << (k / 2), seqSlot)
            `CHK("samplePulse", !(k == 11 || k == 12), samplePulse)
            `CHK("hfGate", (k <= 4 || k == 13), hfGate)
            `CHK("syncClkWave", k <= 1, syncClkWave)
            tick(1);
        end
    endtask

    task automatic check_field(input logic expInject);
        int h0, d0, v0, p0, r0, e0, i0;
        {h0, d0, v0, p0, r0, e0, i0} = {nHr, nHd, nVd, nVp, nRow, nVen, nInj};
        tick(FIELD_CLK);
        `CHK("hReset pulses", 70, nHr - h0)
        `CHK("hData rises", 70, nHd - d0)
        `CHK("vData rises", 7, nVd - v0)
        `CHK("vPhase rises", 35, nVp - p0)
        `CHK("vEnable seen", 1'b1, nVen > e0 && nVen - e0 < FIELD_CLK)
        `CHK("rowLoadGate", 1'b1, nRow > r0 && nRow - r0 < FIELD_CLK)
        `CHK("injectCharge", expInject, nInj > i0)
        `CHK("videoGate", 1'b1, videoGate)
    endtask

    task automatic check_inject();
        int k, r0;
        readoutSel = 1'b1;
        tick(200);
        r0 = nRow;
        tick(200);
        `CHK("rowLoadGate idle", 0, nRow - r0)
        levelHigh = 1'b1;
        for (k = 0; k < 2500 && injectCharge !== 1'b1; k++) tick(1);
        `CHK("injectCharge", 1'b1, injectCharge)
        for (k = 0; k < 200 && hReset !== 1'b1; k++) tick(1);
        `CHK("injectCharge held", 1'b1, injectCharge)
        tick(3);
        `CHK("injectCharge end", 1'b0, injectCharge)
        levelHigh = 1'b0;
        readoutSel = 1'b0;
    endtask

    task automatic check_interlace();
        int k, h0;
        logic g0, g1;
        interlaceSel = 1'b1;
        for (k = 0; k < 2000 && syncGenReset !== 1'b1; k++) tick(1);
        h0 = nHr;
        tick(20);
        g0 = videoGate;
        for (k = 0; k < 2000 && syncGenReset !== 1'b1; k++) tick(1);
        `CHK("lines per field", LPF, nHr - h0)
        tick(20);
        g1 = videoGate;
        `CHK("videoGate field", !g0, g1)
        tick(96);
        `CHK("videoGate line", !g1, videoGate)
    endtask

    initial begin
        #3_000_000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        srst = 1'b1;
        levelHigh = 1'b0;
        readoutSel = 1'b0;
        interlaceSel = 1'b0;
        num_errors = 0;
        comparisons = 0;
        tick(19);
        check_reset();
        tick(1);
        srst = 1'b0;
        tick(100);
        check_rates();
        check_field(1'b0);
        // Level switch in pre-inject mode must not inject
        levelHigh = 1'b1;
        check_field(1'b0);
        levelHigh = 1'b0;
        check_inject();
        check_interlace();
        tally_and_finish();
    end
endmodule // test_imager_scan_timing
